// *** hw/fcs_pkg.sv ***
// constants shared by the flash checksum scanner
package fcs_pkg;
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam int ADDR_W = 14;
    localparam logic [13:0] FLASH_LAST = 14'h3FFF;
    // section select codes
    localparam logic [1:0] SRC_APP_BOOT = 2'h0;
    localparam logic [1:0] SRC_BOOT = 2'h1;
    localparam logic [1:0] SRC_FULL = 2'h2;
    // mode codes
    localparam logic [1:0] MODE_PRIORITY = 2'h0;
    localparam logic [1:0] MODE_SINGLE_BG = 2'h2;
    localparam logic [1:0] MODE_CONT_BG = 2'h3;
    // control field positions and reset values
    localparam int SCAN_CONTROL_A_ENABLE_BIT = 0;
    localparam int SCAN_CONTROL_A_FAIL_INTERRUPT_ENABLE_BIT = 1;
    localparam int SCAN_CONTROL_A_RESET_BIT = 7;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [1:0] SRC_RESET = 2'h0;
    typedef enum logic [1:0] {FCS_IDLE, FCS_SCAN, FCS_CHECK} fcs_state_t;
endpackage : fcs_pkg

// *** hw/fcs_crc_step.sv ***
// one byte step of the ccitt checksum, msb first
`timescale 1ns/10ps
module fcs_crc_step (
    // running value and byte
    input wire logic [15:0] crc_in,
    input wire logic [7:0] data_in,
    // updated value
    output logic [15:0] crc_out
);
    logic [15:0] stage [0:8];
    assign stage[0] = crc_in;
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            assign stage[i+1] = (stage[i][15] ^ data_in[7-i]) ?
                ({stage[i][14:0], 1'b0} ^ fcs_pkg::CRC_POLY) : {stage[i][14:0], 1'b0};
        end
    endgenerate
    assign crc_out = stage[8];
endmodule : fcs_crc_step

// *** hw/fcs_scanner.sv ***
// flash checksum scanner control, section walk and debugger handling
//
// Summary of operation
// - ccitt sixteen bit polynomial checksum
// - preset checksum to all ones
// - bytes from zero, msb first
// - pass when trailing checksum bytes match
// - full, boot, or boot plus application
// - set pass bit on match
// - request nmi on mismatch when enabled
// - pause while cpu sleeps
// - debugger access disables the scanner
// - restart on debug register access, disconnect
// - busy stays one while held
// - debugger status copies without disabling
// - debugger busy zero aborts check
// - debugger busy one schedules single check
// - busy locks mode, source, nmi enable
// - debugger pass zero triggers nmi
// - after nmi reject all writes
// - debugger pass one reads one idle
// - debugger control writes match cpu writes
// - enable write starts check, stays set
// - priority stalls cpu, background yields
// - failure clears pass bit
// - reset strobe clears registers except nmi enable next cycle
`timescale 1ns/10ps
module fcs_scanner (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // section bounds (last byte address)
    input wire logic [13:0] boot_last,
    input wire logic [13:0] app_last,
    // cpu and debugger control writes
    input wire logic cpu_ctrl_a_we,
    input wire logic dbg_ctrl_a_we,
    input wire logic [7:0] scan_control_a_wdata,
    input wire logic cpu_setting_we,
    input wire logic dbg_setting_we,
    input wire logic [7:0] scan_mode_source_setting_wdata,
    // debugger status writes
    input wire logic dbg_busy_we,
    input wire logic dbg_busy_wdata,
    input wire logic dbg_pass_we,
    input wire logic dbg_pass_wdata,
    // debugger activity
    input wire logic dbg_access,
    input wire logic dbg_internal_access,
    input wire logic dbg_disconnect,
    // cpu sleep
    input wire logic cpu_sleep,
    // flash read port
    output logic flash_req,
    output logic [13:0] flash_addr,
    input wire logic flash_grant,
    input wire logic [7:0] flash_rdata,
    // register views and outputs
    output logic [7:0] scan_control_a,
    output logic [7:0] scan_mode_source_setting,
    output logic status_busy,
    output logic status_pass,
    output logic dbg_status_busy,
    output logic dbg_status_pass,
    output logic cpu_stall,
    output logic nmi_req
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    fcs_pkg::fcs_state_t state;
    fcs_pkg::fcs_state_t next_state;
    logic enable;
    logic fail_interrupt_enable;
    logic [1:0] scan_mode;
    logic [1:0] section_select;
    logic busy;
    logic pass;
    logic nmi_fired;
    logic dbg_hold;
    logic reset_pending;
    logic [15:0] crc;
    logic [15:0] crc_next_byte;
    logic [13:0] addr;
    logic [13:0] last_addr;
    logic [15:0] tail;
    logic [15:0] crc_prev;
    logic [15:0] crc_prev2;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    // debugger writes handled as cpu writes
    wire ctrl_a_we = cpu_ctrl_a_we | dbg_ctrl_a_we;
    wire setting_we = cpu_setting_we | dbg_setting_we;
    wire writes_ok = ~nmi_fired;
    wire a_write = ctrl_a_we & writes_ok;
    // an armed interrupt keeps the strobe from cutting a running check
    wire reset_strobe_ok = ~fail_interrupt_enable | ~busy;
    wire reset_req = a_write & scan_control_a_wdata[fcs_pkg::SCAN_CONTROL_A_RESET_BIT] & reset_strobe_ok;
    wire enable_wr = a_write & ~scan_control_a_wdata[fcs_pkg::SCAN_CONTROL_A_RESET_BIT];
    wire start_cpu = enable_wr & scan_control_a_wdata[fcs_pkg::SCAN_CONTROL_A_ENABLE_BIT];
    // rewrite during a check starts over
    wire rewrite_start = start_cpu & (state != fcs_pkg::FCS_IDLE);
    // debugger busy write schedules single check
    wire start_dbg = dbg_busy_we & dbg_busy_wdata & writes_ok & ~busy;
    wire abort_dbg = dbg_busy_we & ~dbg_busy_wdata & writes_ok;
    wire dbg_release = dbg_internal_access | dbg_disconnect;
    wire dbg_restart = dbg_hold & dbg_release;
    // either restart sends the walk back to byte zero
    wire walk_restart = dbg_restart | rewrite_start;
    wire setting_ok = setting_we & writes_ok & ~busy;
    wire fail_interrupt_enable_set = enable_wr & ~busy & scan_control_a_wdata[fcs_pkg::SCAN_CONTROL_A_FAIL_INTERRUPT_ENABLE_BIT];
    wire paused = cpu_sleep | dbg_hold;
    wire is_cont = scan_mode == fcs_pkg::MODE_CONT_BG;
    // a grant that lands while paused is dropped and asked for again
    wire byte_taken = (state == fcs_pkg::FCS_SCAN) & flash_grant & ~paused;
    wire at_last = addr == last_addr;
    // trailing bytes against checksum of the bytes before them
    wire crc_match = tail == crc_prev2;
    wire check_done = state == fcs_pkg::FCS_CHECK;
    // debugger pass zero counts as failure
    wire dbg_fail = dbg_pass_we & ~dbg_pass_wdata & writes_ok;
    wire fail_event = (check_done & ~crc_match) | dbg_fail;

    assign last_addr = (section_select == fcs_pkg::SRC_BOOT) ? boot_last :
        (section_select == fcs_pkg::SRC_FULL) ? fcs_pkg::FLASH_LAST : app_last;

    fcs_crc_step u_step (
        .crc_in(crc),
        .data_in(flash_rdata),
        .crc_out(crc_next_byte)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // next state of the section walk
    always_comb begin
        next_state = state;
        case (state)
            fcs_pkg::FCS_IDLE: begin
                if ((start_cpu | start_dbg) & ~reset_req)
                    next_state = fcs_pkg::FCS_SCAN;
            end
            fcs_pkg::FCS_SCAN: begin
                if (byte_taken & at_last)
                    next_state = fcs_pkg::FCS_CHECK;
            end
            fcs_pkg::FCS_CHECK: begin
                if (crc_match & is_cont & enable)
                    next_state = fcs_pkg::FCS_SCAN;
                else
                    next_state = fcs_pkg::FCS_IDLE;
            end
            default: next_state = fcs_pkg::FCS_IDLE;
        endcase
        // rewrite keeps scanning from byte zero
        if (rewrite_start)
            next_state = fcs_pkg::FCS_SCAN;
        if (reset_pending | abort_dbg)
            next_state = fcs_pkg::FCS_IDLE;
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (rst)
            state <= fcs_pkg::FCS_IDLE;
        else
            state <= next_state;
    end

    // ------------------------------------------------------------
    // address and checksum
    // ------------------------------------------------------------
    // walk address and running checksum
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            addr <= '0;
            crc <= fcs_pkg::CRC_PRESET;
            crc_prev <= fcs_pkg::CRC_PRESET;
            crc_prev2 <= fcs_pkg::CRC_PRESET;
            tail <= '0;
        end else if (state != fcs_pkg::FCS_SCAN || walk_restart) begin
            // start at byte zero
            // a restart drops the partial checksum along with the address
            addr <= '0;
            crc <= fcs_pkg::CRC_PRESET;
            crc_prev <= fcs_pkg::CRC_PRESET;
            crc_prev2 <= fcs_pkg::CRC_PRESET;
        end else if (byte_taken) begin
            addr <= addr + 14'h0001;
            crc <= crc_next_byte;
            // two bytes behind is the checksum the tail is held against
            crc_prev <= crc;
            crc_prev2 <= crc_prev;
            tail <= {tail[7:0], flash_rdata};
        end
    end

    // ------------------------------------------------------------
    // debugger hold and restart
    // ------------------------------------------------------------
    // hold on access, internal reads leave it running
    // an access in the same cycle as a release keeps the hold
    always_ff @(posedge ref_clk) begin
        if (rst)
            dbg_hold <= 1'b0;
        else if (dbg_access)
            dbg_hold <= 1'b1;
        else if (dbg_release)
            dbg_hold <= 1'b0;
    end

    // ------------------------------------------------------------
    // control and status registers
    // ------------------------------------------------------------
    // reset strobe clears registers except nmi enable next cycle
    always_ff @(posedge ref_clk) begin
        if (rst)
            reset_pending <= 1'b0;
        else
            reset_pending <= reset_req;
    end

    // enable and settings
    always_ff @(posedge ref_clk) begin
        if (rst || reset_pending) begin
            enable <= 1'b0;
            scan_mode <= fcs_pkg::MODE_RESET;
            section_select <= fcs_pkg::SRC_RESET;
        end else begin
            // enable stays set after completion
            // a zero lets a continuous walk finish its section, then stop
            if (enable_wr)
                enable <= scan_control_a_wdata[fcs_pkg::SCAN_CONTROL_A_ENABLE_BIT];
            if (setting_ok) begin
                scan_mode <= scan_mode_source_setting_wdata[5:4];
                section_select <= scan_mode_source_setting_wdata[1:0];
            end
        end
    end

    // nmi enable cleared only by system reset
    always_ff @(posedge ref_clk) begin
        if (rst)
            fail_interrupt_enable <= 1'b0;
        else if (fail_interrupt_enable_set)
            fail_interrupt_enable <= 1'b1;
    end

    // busy and pass flags
    always_ff @(posedge ref_clk) begin
        if (rst || reset_pending) begin
            busy <= 1'b0;
            pass <= 1'b0;
        end else begin
            // busy holds while debugger pauses
            // busy follows the next state so it rises with the start write
            busy <= (next_state != fcs_pkg::FCS_IDLE);
            if (fail_event) begin
                pass <= 1'b0;
            end else if (check_done) begin
                pass <= 1'b1;
            end else if (dbg_pass_we & dbg_pass_wdata & writes_ok & ~busy) begin
                pass <= 1'b1;
            end else if (state == fcs_pkg::FCS_IDLE && next_state == fcs_pkg::FCS_SCAN) begin
                pass <= 1'b0;
            end
        end
    end

    // sticky nmi on failure when enabled
    // only system reset lowers the request once raised
    always_ff @(posedge ref_clk) begin
        if (rst)
            nmi_fired <= 1'b0;
        else if (fail_event & fail_interrupt_enable)
            nmi_fired <= 1'b1;
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    // priority stalls cpu, background yields
    wire next_stall = (next_state == fcs_pkg::FCS_SCAN) &
        (scan_mode == fcs_pkg::MODE_PRIORITY) & ~paused;
    // the final grant drops the request so nothing past the section is read
    wire next_req = (next_state == fcs_pkg::FCS_SCAN) & ~paused & ~(byte_taken & at_last);
    wire [13:0] next_addr = byte_taken ? addr + 14'h0001 : addr;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flash_req <= 1'b0;
            flash_addr <= '0;
            cpu_stall <= 1'b0;
            nmi_req <= 1'b0;
        end else begin
            flash_req <= next_req & ~walk_restart;
            // address stands still while the walk is paused
            if (!paused)
                flash_addr <= (state == fcs_pkg::FCS_SCAN && !walk_restart) ?
                    next_addr : 14'h0000;
            cpu_stall <= next_stall;
            nmi_req <= nmi_fired | (fail_event & fail_interrupt_enable);
        end
    end

    // synchronized status copies for the debugger
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            scan_control_a <= 8'h00;
            scan_mode_source_setting <= 8'h00;
            status_busy <= 1'b0;
            status_pass <= 1'b0;
            dbg_status_busy <= 1'b0;
            dbg_status_pass <= 1'b0;
        end else begin
            scan_control_a <= {6'h00, fail_interrupt_enable, enable};
            scan_mode_source_setting <= {2'h0, scan_mode, 2'h0, section_select};
            status_busy <= busy;
            status_pass <= pass;
            dbg_status_busy <= busy;
            dbg_status_pass <= pass;
        end
    end
endmodule : fcs_scanner

// *** verif/fcs_scanner_asserts.sv ***
// port assertions for the flash checksum scanner
`timescale 1ns/10ps
module fcs_scanner_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // watched inputs
    input wire logic cpu_ctrl_a_we,
    input wire logic dbg_ctrl_a_we,
    input wire logic dbg_busy_we,
    input wire logic dbg_access,
    input wire logic dbg_internal_access,
    input wire logic dbg_disconnect,
    input wire logic cpu_sleep,
    input wire logic flash_grant,
    // watched outputs
    input wire logic flash_req,
    input wire logic [13:0] flash_addr,
    input wire logic [7:0] scan_control_a,
    input wire logic [7:0] scan_mode_source_setting,
    input wire logic status_busy,
    input wire logic status_pass,
    input wire logic dbg_status_busy,
    input wire logic cpu_stall,
    input wire logic nmi_req
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_SLEEP_HOLDS_ADDR: assert property (
        $past(cpu_sleep) && !$past(dbg_internal_access) && !$past(dbg_disconnect)
        |-> $stable(flash_addr)) else $error("address moved while asleep");
    AST_REQ_HOLDS: assert property (
        flash_req && !flash_grant && !dbg_access && !$past(dbg_access) && !$past(dbg_access, 2)
        && !dbg_busy_we && !cpu_ctrl_a_we && !dbg_ctrl_a_we && !cpu_sleep
        && !$past(cpu_ctrl_a_we) && !$past(dbg_ctrl_a_we)
        |=> flash_req && $stable(flash_addr)) else $error("request dropped before grant");
    AST_NMI_STICKY: assert property (
        nmi_req |=> nmi_req) else $error("interrupt request fell");
    AST_NMI_NEEDS_EN: assert property (
        $rose(nmi_req) |-> scan_control_a[fcs_pkg::SCAN_CONTROL_A_FAIL_INTERRUPT_ENABLE_BIT])
        else $error("interrupt without enable");
    AST_NMI_PASS_LOW: assert property (
        $rose(nmi_req) |-> ##[0:3] !status_pass) else $error("pass kept after failure");
    AST_LOCK_AFTER_NMI: assert property (
        nmi_req && $past(nmi_req, 3)
        |-> $stable(scan_control_a) && $stable(scan_mode_source_setting))
        else $error("register changed after interrupt");
    AST_STALL_PRIO: assert property (
        cpu_stall |-> scan_mode_source_setting[5:4] == fcs_pkg::MODE_PRIORITY)
        else $error("stall outside priority mode");
    AST_DBG_BUSY_COPY: assert property (
        $rose(status_busy) |-> ##[0:2] dbg_status_busy) else $error("debug busy copy lags");
    // main scenarios reached
    cover property ($rose(nmi_req));
    cover property (cpu_stall && flash_grant);
    cover property (cpu_sleep && flash_req);
endmodule : fcs_scanner_asserts

// *** verif/fcs_flash_model.sv ***
// flash read port model answering the scanner
`timescale 1ns/10ps
module fcs_flash_model (
    // clock and request
    input wire logic ref_clk,
    input wire logic flash_req,
    input wire logic [13:0] flash_addr,
    input wire logic slow,
    // answer
    output logic flash_grant,
    output logic [7:0] flash_rdata
);
    logic [7:0] mem [0:16383];
    logic [7:0] last;
    logic tick;
    // content pattern, sealed later by the bench
    initial begin
        tick = 1'b0;
        last = 8'h00;
        for (int i = 0; i < 16384; i++) mem[i] = 8'(i * 7 + (i >> 8));
    end
    // grant each cycle, or every other one when slow
    assign flash_grant = flash_req && (!slow || tick);
    // data only valid with grant, otherwise inverted last byte
    assign flash_rdata = flash_grant ? mem[flash_addr] : ~last;
    always @(posedge ref_clk) begin
        tick <= ~tick;
        if (flash_grant) last <= flash_rdata;
    end
endmodule : fcs_flash_model

// *** verif/fcs_scanner_bench.sv ***
// self-checking bench for the flash checksum scanner
`timescale 1ns/10ps
module fcs_scanner_bench;
    localparam logic [13:0] BOOT_LAST = 14'h003F;
    localparam logic [13:0] APP_LAST = 14'h00FF;
    logic ref_clk, rst, cw, dw, cs, ds, bwe, bwd, pwe, pwd, acc, ia, dis, slp, slow;
    logic [7:0] wd, rd, ca, ms;
    logic req, gnt, busy, pass, dbusy, dpass, stall, nmi;
    logic [13:0] addr, a;
    logic [1:0] md;
    int fail_count, comparisons, cycles;
    fcs_scanner u_dut (.ref_clk(ref_clk), .rst(rst), .boot_last(BOOT_LAST), .app_last(APP_LAST),
        .cpu_ctrl_a_we(cw), .dbg_ctrl_a_we(dw), .scan_control_a_wdata(wd),
        .cpu_setting_we(cs), .dbg_setting_we(ds), .scan_mode_source_setting_wdata(wd),
        .dbg_busy_we(bwe), .dbg_busy_wdata(bwd), .dbg_pass_we(pwe), .dbg_pass_wdata(pwd),
        .dbg_access(acc), .dbg_internal_access(ia), .dbg_disconnect(dis), .cpu_sleep(slp),
        .flash_req(req), .flash_addr(addr), .flash_grant(gnt), .flash_rdata(rd),
        .scan_control_a(ca), .scan_mode_source_setting(ms), .status_busy(busy),
        .status_pass(pass), .dbg_status_busy(dbusy), .dbg_status_pass(dpass),
        .cpu_stall(stall), .nmi_req(nmi));
    fcs_flash_model u_flash (.ref_clk(ref_clk), .flash_req(req), .flash_addr(addr),
        .slow(slow), .flash_grant(gnt), .flash_rdata(rd));
    // clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic summarize();
        if (fail_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic do_reset();
        rst = 1'b1;
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
    endtask : do_reset
    // one write pulse: 0 cpu control, 1 debugger control, 2 cpu setting, 3 debugger setting
    task automatic wr(input int k, input logic [7:0] v);
        @(negedge ref_clk);
        wd = v;
        {cw, dw, cs, ds} = 4'b1000 >> k;
        @(negedge ref_clk);
        {cw, dw, cs, ds} = 4'h0;
        repeat (3) @(negedge ref_clk);
    endtask : wr
    // debugger pulse {busy we, busy data, pass we, pass data, access, internal, disconnect}
    task automatic dbg(input logic [6:0] p);
        @(negedge ref_clk);
        {bwe, bwd, pwe, pwd, acc, ia, dis} = p;
        @(negedge ref_clk);
        {bwe, bwd, pwe, pwd, acc, ia, dis} = 7'h00;
        repeat (3) @(negedge ref_clk);
    endtask : dbg
    task automatic done();
        for (int n = 0; n < 20000 && busy !== 1'b0; n++) @(negedge ref_clk);
        repeat (3) @(negedge ref_clk);
    endtask : done
    // msb-first step of the expected checksum
    function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? fcs_pkg::CRC_POLY : 16'h0000);
        return c;
    endfunction : crc
    // store the checksum of the preceding bytes in the last two
    task automatic seal(input int last);
        logic [15:0] c;
        c = fcs_pkg::CRC_PRESET;
        for (int i = 0; i < last - 1; i++) c = crc(c, u_flash.mem[i]);
        u_flash.mem[last - 1] = c[15:8];
        u_flash.mem[last] = c[7:0];
    endtask : seal
    initial begin
        {cw, dw, cs, ds, bwe, bwd, pwe, pwd, acc, ia, dis, slp, slow} = 13'h0000;
        wd = 8'h00;
        do_reset();
        seal(int'(BOOT_LAST));
        seal(int'(APP_LAST));
        seal(int'(fcs_pkg::FLASH_LAST));
        for (int s = 0; s < 3; s++) begin
            slow = (s == 1);
            md = (s == 0) ? fcs_pkg::MODE_PRIORITY : fcs_pkg::MODE_SINGLE_BG;
            wr(2, {2'h0, md, 2'h0, 2'(s)});
            wr(0, 8'h01);
            chk(stall, s == 0);
            done();
            chk({pass, ca}, 9'h101);
        end
        u_flash.mem[5] = ~u_flash.mem[5];
        wr(2, 8'h21);
        wr(1, 8'h01);
        done();
        chk({pass, nmi}, 2'b00);
        u_flash.mem[5] = ~u_flash.mem[5];
        wr(0, 8'h01);
        slp = 1'b1;
        repeat (2) @(negedge ref_clk);
        a = addr;
        repeat (20) @(negedge ref_clk);
        chk(addr, a);
        slp = 1'b0;
        done();
        chk(pass, 1'b1);
        wr(0, 8'h01);
        dbg(7'h04);
        a = addr;
        repeat (20) @(negedge ref_clk);
        chk({addr, busy, dbusy}, {a, 2'b11});
        dbg(7'h02);
        done();
        chk({pass, dpass}, 2'b11);
        wr(0, 8'h01);
        dbg(7'h04);
        dbg(7'h40);
        dbg(7'h01);
        chk({busy, req}, 2'b00);
        dbg(7'h04);
        dbg(7'h60);
        chk(req, 1'b0);
        dbg(7'h01);
        chk(busy, 1'b1);
        done();
        chk(pass, 1'b1);
        wr(0, 8'h01);
        wr(0, 8'h01);
        chk(addr, 14'h0002);
        wr(0, 8'h01);
        wr(3, 8'h02);
        chk(ms, 8'h21);
        done();
        wr(0, 8'h80);
        chk({ca, ms, pass}, 17'h00000);
        dbg(7'h18);
        chk({pass, dpass}, 2'b11);
        wr(0, 8'h02);
        dbg(7'h10);
        chk({nmi, pass}, 2'b10);
        wr(2, 8'h21);
        chk(ms, 8'h00);
        do_reset();
        u_flash.mem[5] = ~u_flash.mem[5];
        wr(2, 8'h21);
        wr(0, 8'h03);
        done();
        chk({nmi, pass}, 2'b10);
        summarize();
    end
endmodule : fcs_scanner_bench
bind fcs_scanner fcs_scanner_asserts u_chk (.ref_clk, .rst, .cpu_ctrl_a_we, .dbg_ctrl_a_we,
    .dbg_busy_we, .dbg_access, .dbg_internal_access, .dbg_disconnect, .cpu_sleep,
    .flash_grant, .flash_req, .flash_addr, .scan_control_a, .scan_mode_source_setting,
    .status_busy, .status_pass, .dbg_status_busy, .cpu_stall, .nmi_req);
